/* inc/prog_mem_pkg.sv */
// constants, carriers and register map for the program memory table-read unit
// assumes a single system clock; the core runs four clock phases per instruction cycle
package prog_mem_pkg;

   // code store geometry
   localparam int ADDR_W = 11;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int CODE_WORDS = 2048;
   localparam logic [10:0] RESET_VECTOR = 11'h000;
   localparam logic [2:0] LAST_PAGE_BITS = 3'h7;
   // stored bits of the high table byte; missing bits read as zero
   localparam logic [7:0] HIGH_STORED_MASK = 8'hFF;

   // instruction cycle: T1..T4, one system clock each
   localparam int PHASES = 4;
   localparam logic [1:0] PH_FETCH = 2'h0;
   localparam logic [1:0] PH_DATA = 2'h1;
   localparam logic [1:0] PH_LAST = 2'h3;

   // register byte offsets
   localparam logic [7:0] OFS_PTR_LOW = 8'h00;
   localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
   localparam logic [7:0] OFS_HIGH_BYTE = 8'h08;
   localparam logic [7:0] OFS_TBL_CMD = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_LAST_LOW = 8'h14;
   localparam logic [7:0] OFS_FLASH_ADDR = 8'h18;
   localparam logic [7:0] OFS_FLASH_DATA = 8'h1C;
   localparam logic [7:0] OFS_TBL_COUNT = 8'h20;

   // field positions
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_LAST_BIT = 1;
   localparam int CMD_DEST_LSB = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_EV_BIT = 1;
   localparam int ST_PCLK_BIT = 2;
   localparam int ST_PDAT_BIT = 3;
   localparam int ST_PC_LSB = 16;

   // reset values
   localparam logic [7:0] PTR_LOW_RST = 8'h00;
   localparam logic [2:0] PTR_HIGH_RST = 3'h0;
   localparam logic [7:0] HIGH_BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_TABLE = 2'b10
   } fsm_t;

   // table read request from the core
   typedef struct packed {
      logic valid;
      logic last_page;
      logic [7:0] dest;
   } tbl_cmd_t;

   // pointer register write from the core
   typedef struct packed {
      logic strobe;
      logic sel_high;
      logic [7:0] data;
   } ptr_wr_t;

   // data memory write towards the core
   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } dm_wr_t;

   // fetched instruction towards the core
   typedef struct packed {
      logic valid;
      logic [10:0] addr;
      logic [15:0] word;
   } fetch_t;

endpackage

/* verilog/prog_code_store.sv */
// 2K x 16 code store: one synchronous read port, one write port
// assumes reads and writes come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module prog_code_store #(
   parameter int ADDR_W = 11,
   parameter int WORD_W = 16,
   parameter int DEPTH = 2048
) (
   // clock
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // read port
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [WORD_W-1:0] rd_data,
   // write port
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [WORD_W-1:0] wr_data
);
   logic [WORD_W-1:0] mem [DEPTH];

   always_ff @(posedge hclk) begin
      if (ce && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_data <= '0;
      end else if (ce && rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // prog_code_store
`default_nettype wire

/* verilog/program_memory_table_read.sv */
// program memory access unit: instruction fetch, table reads, register slave
// assumes an AHB-Lite master, a core on the same clock, pins on their own timing
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read
   import prog_mem_pkg::*;
#(
   parameter int DEPTH = CODE_WORDS
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // core side
   input wire tbl_cmd_t tbl_cmd,
   input wire ptr_wr_t ptr_wr,
   input wire logic pc_load,
   input wire logic [10:0] pc_target,
   output fetch_t fetch,
   output dm_wr_t dm_wr,
   output logic tbl_busy,
   // programming / debug pins (pin 0 data, pin 1 clock)
   input wire logic prog_serial_data_in,
   input wire logic prog_serial_clock_in,
   output logic prog_serial_data_out,
   output logic prog_serial_data_oe,
   // emulation strap and shared pin functions
   input wire logic ev_strap,
   input wire logic [1:0] shared_func_out,
   input wire logic [1:0] shared_func_oe,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe
);

   typedef struct packed {
      fsm_t fsm;
      logic [1:0] phase;
      logic [10:0] pc;
      logic [7:0] ptr_low;
      logic [2:0] ptr_high;
      logic [7:0] high_byte;
      logic [7:0] last_low;
      logic [15:0] tbl_count;
      logic pend;
      logic pend_last;
      logic [7:0] pend_dest;
      logic cur_last;
      logic [7:0] cur_dest;
      fetch_t fetch;
      dm_wr_t dm_wr;
      logic [10:0] flash_addr;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic rd_wait;
      logic [31:0] hrdata;
      logic [1:0] sync_clk;
      logic [1:0] sync_dat;
      logic ev_mode;
      logic ev_taken;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [15:0] mem_rdata;
   logic mem_rd_en;
   logic [10:0] mem_rd_addr;
   logic mem_wr_en;
   logic [10:0] mem_wr_addr;
   logic [15:0] mem_wr_data;
   logic addr_accept;

   // table address from the pointers
   function automatic logic [10:0] table_addr(input logic [7:0] lo, input logic [2:0] hi,
                                              input logic last);
      table_addr = {(last ? LAST_PAGE_BITS : hi), lo};
   endfunction

   // register read decode
   function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] ofs);
      read_mux = 32'h0000_0000;
      case (ofs)
         OFS_PTR_LOW: read_mux[7:0] = s.ptr_low;
         OFS_PTR_HIGH: read_mux[2:0] = s.ptr_high;
         OFS_HIGH_BYTE: read_mux[7:0] = s.high_byte & HIGH_STORED_MASK;
         OFS_STATUS: begin
            read_mux[ST_BUSY_BIT] = (s.fsm == ST_TABLE) || s.pend;
            read_mux[ST_EV_BIT] = s.ev_mode;
            read_mux[ST_PCLK_BIT] = s.sync_clk[1];
            read_mux[ST_PDAT_BIT] = s.sync_dat[1];
            read_mux[ST_PC_LSB +: 11] = s.pc;
         end
         OFS_LAST_LOW: read_mux[7:0] = s.last_low;
         OFS_FLASH_ADDR: read_mux[10:0] = s.flash_addr;
         OFS_TBL_COUNT: read_mux[15:0] = s.tbl_count;
         default: read_mux = 32'h0000_0000;
      endcase
   endfunction

   prog_code_store #(
      .ADDR_W(ADDR_W),
      .WORD_W(WORD_W),
      .DEPTH(DEPTH)
   ) u_store (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .rd_en(mem_rd_en),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rdata),
      .wr_en(mem_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data)
   );

   // store port: table fetch in the first phase of the table cycle, else instruction
   always_comb begin
      mem_rd_en = (state_reg.phase == PH_FETCH);
      if (state_reg.fsm == ST_TABLE) begin
         mem_rd_addr = table_addr(state_reg.ptr_low, state_reg.ptr_high, state_reg.cur_last);
      end else begin
         mem_rd_addr = state_reg.pc;
      end
   end

   assign addr_accept = hsel && htrans[1] && hready;
   assign mem_wr_en = state_reg.dp_valid && state_reg.dp_write && !state_reg.rd_wait &&
                      (state_reg.dp_addr == OFS_FLASH_DATA);
   assign mem_wr_addr = state_reg.flash_addr;
   assign mem_wr_data = hwdata[15:0];

   always_comb begin
      state_next = state_reg;
      state_next.fetch.valid = 1'b0;
      state_next.dm_wr.strobe = 1'b0;

      // pin inputs through two flops
      state_next.sync_clk = {state_reg.sync_clk[0], prog_serial_clock_in};
      state_next.sync_dat = {state_reg.sync_dat[0], prog_serial_data_in};
      // emulation strap caught once after reset release
      if (!state_reg.ev_taken) begin
         state_next.ev_mode = ev_strap;
         state_next.ev_taken = 1'b1;
      end

      // instruction cycle phase counter
      state_next.phase = (state_reg.phase == 2'(PHASES - 1)) ? PH_FETCH : state_reg.phase + 2'h1;

      case (state_reg.fsm)
         ST_RUN: begin
            if (state_reg.phase == PH_DATA) begin
               state_next.fetch.valid = 1'b1;
               state_next.fetch.addr = state_reg.pc;
               state_next.fetch.word = mem_rdata;
               state_next.pc = state_reg.pc + 11'h001;
            end
            if (state_reg.phase == PH_LAST && state_reg.pend) begin
               // next instruction cycle is the table cycle; pc stays put
               state_next.fsm = ST_TABLE;
               state_next.cur_last = state_reg.pend_last;
               state_next.cur_dest = state_reg.pend_dest;
               state_next.pend = 1'b0;
            end
         end
         ST_TABLE: begin
            if (state_reg.phase == PH_DATA) begin
               state_next.dm_wr.strobe = 1'b1;
               state_next.dm_wr.addr = state_reg.cur_dest;
               state_next.dm_wr.data = mem_rdata[7:0];
               state_next.last_low = mem_rdata[7:0];
               state_next.high_byte = mem_rdata[15:8] & HIGH_STORED_MASK;
               state_next.tbl_count = state_reg.tbl_count + 16'h0001;
            end
            if (state_reg.phase == PH_LAST) begin
               state_next.fsm = ST_RUN;
            end
         end
         default: state_next.fsm = ST_RUN;
      endcase

      // jump from the core takes effect at the end of the cycle
      if (pc_load && state_reg.phase == PH_LAST) begin
         state_next.pc = pc_target;
      end

      // table request: core first, then a software command
      if (tbl_cmd.valid && !state_reg.pend) begin
         state_next.pend = 1'b1;
         state_next.pend_last = tbl_cmd.last_page;
         state_next.pend_dest = tbl_cmd.dest;
      end else if (state_reg.dp_valid && state_reg.dp_write && !state_reg.pend &&
                   state_reg.dp_addr == OFS_TBL_CMD && hwdata[CMD_GO_BIT]) begin
         state_next.pend = 1'b1;
         state_next.pend_last = hwdata[CMD_LAST_BIT];
         state_next.pend_dest = hwdata[CMD_DEST_LSB +: 8];
      end

      // bus slave: writes in the data phase, reads take one wait state
      if (state_reg.dp_valid && !state_reg.dp_write && state_reg.rd_wait) begin
         state_next.hrdata = read_mux(state_reg, state_reg.dp_addr);
         state_next.rd_wait = 1'b0;
      end else begin
         if (state_reg.dp_valid && state_reg.dp_write) begin
            case (state_reg.dp_addr)
               OFS_PTR_LOW: state_next.ptr_low = hwdata[7:0];
               OFS_PTR_HIGH: state_next.ptr_high = hwdata[2:0];
               OFS_FLASH_ADDR: state_next.flash_addr = hwdata[10:0];
               OFS_FLASH_DATA: state_next.flash_addr = state_reg.flash_addr + 11'h001;
               default: ; // high byte and read-only registers: ignored; table command taken above
            endcase
         end
         state_next.dp_valid = addr_accept;
         state_next.dp_write = hwrite;
         state_next.dp_addr = {haddr[7:2], 2'b00};
         state_next.rd_wait = addr_accept && !hwrite;
      end

      // core pointer writes win over the bus in the same cycle
      if (ptr_wr.strobe) begin
         if (ptr_wr.sel_high) begin
            state_next.ptr_high = ptr_wr.data[2:0];
         end else begin
            state_next.ptr_low = ptr_wr.data;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '0;
         state_reg.fsm <= ST_RUN;
         state_reg.pc <= RESET_VECTOR;
         state_reg.phase <= PH_FETCH;
         state_reg.ptr_low <= PTR_LOW_RST;
         state_reg.ptr_high <= PTR_HIGH_RST;
         state_reg.high_byte <= HIGH_BYTE_RST;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // outputs
   assign hreadyout = !(state_reg.dp_valid && !state_reg.dp_write && state_reg.rd_wait);
   assign hresp = 1'b0;
   assign hrdata = state_reg.hrdata;
   assign fetch = state_reg.fetch;
   assign dm_wr = state_reg.dm_wr;
   assign tbl_busy = (state_reg.fsm == ST_TABLE) || state_reg.pend;

   // serial line stays released; the programmer drives data and clock
   assign prog_serial_data_out = 1'b0;
   assign prog_serial_data_oe = 1'b0;

   // emulation: shared functions off, pins left to programming and debug
   assign pin_out = state_reg.ev_mode ? 2'b00 : shared_func_out;
   assign pin_oe = state_reg.ev_mode ? 2'b00 : shared_func_oe;

endmodule // program_memory_table_read
`default_nettype wire

/* test/core_model.sv */
// core model: pointer writes and table-read requests towards the unit
// assumes the unit answers on dm_wr and paces fetches on fetch
`timescale 1ns/1ps
`default_nettype none
module core_model
   import prog_mem_pkg::*;
(
   // clock
   input wire logic hclk,
   // from the unit
   input wire fetch_t fetch,
   input wire dm_wr_t dm_wr,
   // to the unit
   output tbl_cmd_t tbl_cmd,
   output ptr_wr_t ptr_wr
);
   initial begin
      tbl_cmd = '0;
      ptr_wr = '0;
   end

   task automatic set_ptr(input logic hi, input logic [7:0] d);
      @(posedge hclk);
      ptr_wr <= {1'b1, hi, d};
      @(posedge hclk);
      ptr_wr <= {1'b0, ~hi, ~d};
   endtask

   // one read in flight; issued right after a fetch
   task automatic table_read(input logic last, input logic [7:0] dest, output dm_wr_t got);
      do @(posedge hclk); while (fetch.valid !== 1'b1);
      tbl_cmd <= {1'b1, last, dest};
      @(posedge hclk);
      tbl_cmd <= {1'b0, ~last, ~dest};
      do @(posedge hclk); while (dm_wr.strobe !== 1'b1);
      got = dm_wr;
   endtask
endmodule // core_model
`default_nettype wire

/* test/program_memory_table_read_sva.sv */
// checker for the table-read unit, bound to its top module
// assumes ce high and pc_load idle while fetch order is watched
`timescale 1ns/1ps
`default_nettype none
module pmtr_checker
   import prog_mem_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // core side
   input wire tbl_cmd_t tbl_cmd,
   input wire fetch_t fetch,
   input wire dm_wr_t dm_wr,
   input wire logic tbl_busy,
   // pins
   input wire logic prog_serial_data_oe,
   input wire logic ev_strap,
   input wire logic [1:0] shared_func_oe,
   input wire logic [1:0] pin_oe
);
   logic seen_fetch;
   logic have_ev;
   logic ev_q;
   logic [10:0] last_addr;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_fetch <= 1'b0;
         have_ev <= 1'b0;
         ev_q <= 1'b0;
         last_addr <= '0;
      end else begin
         if (ce && !have_ev) begin
            ev_q <= ev_strap;
            have_ev <= 1'b1;
         end
         if (fetch.valid) begin
            seen_fetch <= 1'b1;
            last_addr <= fetch.addr;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence take;
      tbl_cmd.valid && !tbl_busy && ce;
   endsequence
   sequence table_slot;
      (!fetch.valid)[*4] ##1 fetch.valid;
   endsequence

   reset_vector_a: assert property (fetch.valid && !seen_fetch |-> fetch.addr == RESET_VECTOR)
      else $error("first fetch not at reset vector");
   pc_step_a: assert property (fetch.valid && seen_fetch |-> fetch.addr == last_addr + 11'h1)
      else $error("fetch address not sequential");
   fetch_cadence_a: assert property (fetch.valid |=> (!fetch.valid)[*3] ##1 (fetch.valid or table_slot))
      else $error("fetch spacing wrong");
   table_gap_a: assert property (dm_wr.strobe |-> table_slot)
      else $error("fetch during table cycle");
   take_answer_a: assert property (take |-> ##[4:7] dm_wr.strobe)
      else $error("table read not answered");
   busy_hold_a: assert property (take |=> tbl_busy [*2])
      else $error("busy not held after request");
   dm_pulse_a: assert property (dm_wr.strobe |=> !dm_wr.strobe)
      else $error("data write strobe too long");
   prog_release_a: assert property (!prog_serial_data_oe)
      else $error("programming data line driven");
   pin_share_a: assert property (have_ev |-> pin_oe == (ev_q ? 2'h0 : shared_func_oe))
      else $error("shared pin enable wrong");
endmodule // pmtr_checker

bind program_memory_table_read pmtr_checker u_chk (
   .hclk, .hresetn, .ce, .tbl_cmd, .fetch, .dm_wr, .tbl_busy,
   .prog_serial_data_oe, .ev_strap, .shared_func_oe, .pin_oe
);
`default_nettype wire

/* test/testbench.sv */
// testbench: ahb-lite master, core model, table-read scenarios
// assumes a single 100 MHz clock and the unit's register map
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import prog_mem_pkg::*;
   logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, pc_load = 0, ev_strap = 0;
   logic pdat = 0, pclk = 0, hreadyout, hresp, tbl_busy, psdo, psoe, last;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
   logic [1:0] htrans = '0, sf_out = '0, sf_oe = '0, pin_out, pin_oe;
   logic [2:0] hsize = 3'h2, hi;
   logic [10:0] pc_target = '0;
   logic [7:0] lo, dest;
   logic [15:0] w;
   tbl_cmd_t tbl_cmd;
   ptr_wr_t ptr_wr;
   fetch_t fetch;
   dm_wr_t dm_wr, got;
   int n_fail = 0, n_checks = 0;

   always #5 hclk = ~hclk;

   program_memory_table_read dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tbl_cmd(tbl_cmd), .ptr_wr(ptr_wr),
      .pc_load(pc_load), .pc_target(pc_target), .fetch(fetch), .dm_wr(dm_wr), .tbl_busy(tbl_busy),
      .prog_serial_data_in(pdat), .prog_serial_clock_in(pclk), .prog_serial_data_out(psdo),
      .prog_serial_data_oe(psoe), .ev_strap(ev_strap), .shared_func_out(sf_out),
      .shared_func_oe(sf_oe), .pin_out(pin_out), .pin_oe(pin_oe));
   core_model u_core (.hclk(hclk), .fetch(fetch), .dm_wr(dm_wr), .tbl_cmd(tbl_cmd), .ptr_wr(ptr_wr));

   always @(posedge hclk) begin
      sf_out <= 2'($urandom);
      sf_oe <= 2'($urandom);
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask

   task automatic store(input logic [10:0] a, input logic [15:0] d);
      bus(1'b1, OFS_FLASH_ADDR, {21'h0, a}, rv);
      bus(1'b1, OFS_FLASH_DATA, {16'h0, d}, rv);
   endtask

   function automatic logic [10:0] tbl_addr(input logic lp, input logic [2:0] h, input logic [7:0] l);
      return lp ? {LAST_PAGE_BITS, l} : {h, l};
   endfunction

   // programming pins are driven by the bench alone
   task automatic pins_check;
      pdat <= 1'($urandom);
      pclk <= 1'($urandom);
      repeat (4) @(posedge hclk);
      bus(1'b0, OFS_STATUS, 32'h0, rv);
      chk("prog pins", {30'h0, pdat, pclk}, {30'h0, rv[3:2]});
      chk("prog oe", 32'h0, {31'h0, psoe});
      chk("prog data out", 32'h0, {31'h0, psdo});
      chk("bus response", 32'h0, {31'h0, hresp});
      chk("pin out", {30'h0, ev_strap ? 2'h0 : sf_out}, {30'h0, pin_out});
      chk("pin oe", {30'h0, ev_strap ? 2'h0 : sf_oe}, {30'h0, pin_oe});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge hclk);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      void'($urandom(32'hCE67));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      do @(posedge hclk); while (fetch.valid !== 1'b1);
      chk("first fetch", 32'h0, {21'h0, fetch.addr});
      bus(1'b0, OFS_HIGH_BYTE, 32'h0, rv);
      chk("high byte reset", {24'h0, HIGH_BYTE_RST}, rv);
      bus(1'b0, 8'h3C, 32'h0, rv);
      chk("unmapped read", 32'h0, rv);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         last = i[0];
         hi = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
         lo = (i < 2) ? 8'hFF : 8'($urandom);
         w = 16'($urandom);
         dest = 8'($urandom);
         store(last ? {hi, lo} : {LAST_PAGE_BITS, lo}, ~w);
         store(tbl_addr(last, hi, lo), w);
         u_core.set_ptr(1'b0, lo);
         u_core.set_ptr(1'b1, {5'($urandom), hi});
         bus(1'b0, OFS_PTR_LOW, 32'h0, rv);
         chk("pointer low", {24'h0, lo}, rv);
         u_core.table_read(last, dest, got);
         chk("dest register", {24'h0, dest}, {24'h0, got.addr});
         chk("low table byte", {24'h0, w[7:0]}, {24'h0, got.data});
         bus(1'b0, OFS_HIGH_BYTE, 32'h0, rv);
         chk("high byte", {24'h0, w[15:8] & HIGH_STORED_MASK}, rv);
         bus(1'b1, OFS_HIGH_BYTE, ~rv, rv);
         bus(1'b0, OFS_HIGH_BYTE, 32'h0, rv);
         chk("high byte kept", {24'h0, w[15:8] & HIGH_STORED_MASK}, rv);
         $display("test table read %0d at %h done", i, tbl_addr(last, hi, lo));
      end
      // software command re-reads the last-page word of the final loop pass
      bus(1'b1, OFS_TBL_CMD, {16'h0, dest, 8'h03}, rv);
      do @(posedge hclk); while (dm_wr.strobe !== 1'b1);
      chk("command dest", {24'h0, dest}, {24'h0, dm_wr.addr});
      chk("command low byte", {24'h0, w[7:0]}, {24'h0, dm_wr.data});
      bus(1'b0, OFS_LAST_LOW, 32'h0, rv);
      chk("last low byte", {24'h0, w[7:0]}, rv);
      bus(1'b0, OFS_TBL_COUNT, 32'h0, rv);
      chk("table count", 32'h9, rv);
      bus(1'b0, OFS_HIGH_BYTE, 32'h0, rv);
      chk("command high byte", {24'h0, w[15:8] & HIGH_STORED_MASK}, rv);
      store(11'h000, 16'hA5C3);
      $display("test software table read done");
      pins_check;
      $display("test programming pins done");
      @(posedge hclk);
      hresetn <= 1'b0;
      ev_strap <= 1'b1;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      do @(posedge hclk); while (fetch.valid !== 1'b1);
      chk("fetch after reset", 32'h0, {21'h0, fetch.addr});
      chk("reset vector word", 32'h0000_A5C3, {16'h0, fetch.word});
      bus(1'b0, OFS_STATUS, 32'h0, rv);
      chk("emulation mode", 32'h1, {31'h0, rv[1]});
      chk("shared pin oe", 32'h0, {30'h0, pin_oe});
      pins_check;
      $display("test emulation pins done");
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
